// ==== logic/rml_ref_monitor.v ====
// reference input monitors, validation timers and pll lock detectors with wishbone registers
`timescale 1ns/1ps
`include "rml_defines.vh"

module rml_ref_monitor (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [`RML_ADR_W-1:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // reference inputs, asynchronous
   input wire [1:0] ref_clk_in,
   // selection logic
   input wire ref_selected,
   output reg [1:0] ref_qualified,
   // pll error samples
   input wire lock_err_valid,
   input wire [15:0] dpll_freq_err,
   input wire [15:0] dpll_phase_err,
   input wire [15:0] resonator_freq_err,
   // lock and status outputs
   output reg freq_lock_loss_flag,
   output reg phase_lock_loss_flag,
   output reg apll_lock_loss_flag,
   output reg lock_loss_status,
   output reg [1:0] status_pin
);

   // ==========================================
   // functions
   function hyst;
      input cur;
      input [31:0] val;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if (val < {16'h0000, lo})
            hyst = 1'b0;
         else if (val > {16'h0000, hi})
            hyst = 1'b1;
         else
            hyst = cur;
      end
   endfunction

   // larger averaging leaves fewer usable threshold bits
   function [15:0] clamp_thr;
      input [15:0] thr;
      input [2:0] avg;
      reg [15:0] lim;
      begin
         lim = `RML_THR_MAX >> avg;
         clamp_thr = (thr > lim) ? lim : thr;
      end
   endfunction

   function pick;
      input [3:0] code;
      input [1:0] f_freq;
      input [1:0] f_win;
      input [1:0] f_phv;
      input [1:0] f_qual;
      input [3:0] lk;
      begin
         case (code[2:0])
            `RML_SRC_FREQ: pick = f_freq[code[3]];
            `RML_SRC_WIN: pick = f_win[code[3]];
            `RML_SRC_PHV: pick = f_phv[code[3]];
            `RML_SRC_QUAL: pick = f_qual[code[3]];
            `RML_SRC_FREQ_LOCK_LOSS_FLAG: pick = lk[0];
            `RML_SRC_PHASE_LOCK_LOSS_FLAG: pick = lk[1];
            `RML_SRC_RLOFL: pick = lk[2];
            default: pick = lk[3];
         endcase
      end
   endfunction

   // ==========================================
   // register storage
   reg [31:0] cfg [0:`RML_CFG_WORDS-1];
   reg [31:0] route;
   reg [31:0] flock;
   reg [31:0] plock;
   reg [31:0] rlock;
   reg [31:0] lcfg;
   wire [1:0] ref_freq_fault_flag;
   wire [1:0] ref_window_fault_flag;
   wire [1:0] ref_phv_fault_flag;
   wire [1:0] qual_int;
   wire [`RML_IDX_W-1:0] idx = wb_adr_i[6:2];
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire cfg_hit = ~idx[4];
   wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   reg [31:0] next_dat;
   integer k;

   // ==========================================
   // wishbone slave: ack one cycle after request
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `RML_RST_WORD;
         route <= `RML_RST_WORD;
         flock <= `RML_RST_WORD;
         plock <= `RML_RST_WORD;
         rlock <= `RML_RST_WORD;
         lcfg <= `RML_RST_WORD;
         for (k = 0; k < `RML_CFG_WORDS; k = k + 1)
            cfg[k] <= `RML_RST_WORD;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? next_dat : `RML_RST_WORD;
         if (bus_req && wb_we_i) begin
            if (cfg_hit)
               cfg[idx[3:0]] <= (cfg[idx[3:0]] & ~wmask) | (wb_dat_i & wmask);
            case (idx)
               `RML_REG_ROUTE: route <= (route & ~wmask) | (wb_dat_i & wmask);
               `RML_REG_FLOCK: flock <= (flock & ~wmask) | (wb_dat_i & wmask);
               `RML_REG_PLOCK: plock <= (plock & ~wmask) | (wb_dat_i & wmask);
               `RML_REG_RLOCK: rlock <= (rlock & ~wmask) | (wb_dat_i & wmask);
               `RML_REG_LCFG: lcfg <= (lcfg & ~wmask) | (wb_dat_i & wmask);
               default: ;
            endcase
         end
      end
   end

   always @* begin
      next_dat = `RML_RST_WORD;
      if (cfg_hit)
         next_dat = cfg[idx[3:0]];
      else begin
         case (idx)
            `RML_REG_ROUTE: next_dat = route;
            // status bits of the selected input, window flags of both inputs above them
            `RML_REG_STATUS: next_dat = {22'h000000, ref_window_fault_flag, 3'h0, ref_selected,
               qual_int[ref_selected], ref_phv_fault_flag[ref_selected],
               ref_window_fault_flag[ref_selected], ref_freq_fault_flag[ref_selected]};
            `RML_REG_FLOCK: next_dat = flock;
            `RML_REG_PLOCK: next_dat = plock;
            `RML_REG_RLOCK: next_dat = rlock;
            `RML_REG_LCFG: next_dat = lcfg;
            `RML_REG_LSTAT: next_dat = {28'h0000000, lock_loss_status, apll_lock_loss_flag,
               phase_lock_loss_flag, freq_lock_loss_flag};
            default: next_dat = `RML_RST_WORD;
         endcase
      end
   end

   // ==========================================
   // per-input monitors
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
         localparam integer B = gi * `RML_IN_STRIDE;
         reg s1, s2, s3;
         reg [31:0] gcnt;
         reg [23:0] ecnt;
         reg [31:0] fsum;
         reg [7:0] fnum;
         reg fflag;
         reg [31:0] wcnt;
         reg late_f, early_f, phv_f;
         reg [31:0] vcnt;
         reg qual;
         wire [31:0] ctrl = cfg[B + `RML_REG_CTRL];
         wire [31:0] fthr = cfg[B + `RML_REG_FTHR];
         wire [31:0] fgate = cfg[B + `RML_REG_FGATE];
         wire [3:0] acc = cfg[B + `RML_REG_FCFG][3:0];
         wire [2:0] avg = cfg[B + `RML_REG_FCFG][6:4];
         wire [31:0] wnom = cfg[B + `RML_REG_WNOM];
         wire [31:0] wwin = cfg[B + `RML_REG_WWIN];
         wire [31:0] pjit = cfg[B + `RML_REG_PJIT];
         wire [31:0] vtime = cfg[B + `RML_REG_VTIME];
         wire edge_seen = s2 & ~s3;
         // phase valid excludes the ppm detector
         wire phv_en = ctrl[`RML_CTRL_PHV_EN];
         wire freq_en = ctrl[`RML_CTRL_FREQ_EN] & ~phv_en;
         wire late_en = ctrl[`RML_CTRL_LATE_EN];
         wire early_en = ctrl[`RML_CTRL_EARLY_EN] & late_en;
         // nominal edge count per gate, one count = 2^acc ppm
         wire [23:0] nom = `RML_PPM_FULL >> acc;
         wire [23:0] ecnt_now = ecnt + {23'h000000, edge_seen};
         wire [23:0] err = (ecnt_now > nom) ? ecnt_now - nom : nom - ecnt_now;
         wire [23:0] err_ppm = err << acc;
         wire [31:0] fsum_now = fsum + {8'h00, err_ppm};
         wire gate_end = (gcnt >= fgate);
         wire avg_end = (fnum == ((8'h01 << avg) - 8'h01));
         wire [31:0] late_lim = wnom + {16'h0000, wwin[15:0]};
         wire [31:0] early_lim = wnom - {16'h0000, wwin[31:16]};
         wire [31:0] phv_hi = wnom + pjit;
         wire [31:0] phv_lo = wnom - pjit;
         wire any_flag = fflag | late_f | early_f | phv_f;

         // pin sampled by two flip-flops before use
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end else begin
               s1 <= ref_clk_in[gi];
               s2 <= s1;
               s3 <= s2;
            end
         end

         // count edges over a gate timed by the oscillator clock
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               gcnt <= 32'h00000000;
               ecnt <= 24'h000000;
               fsum <= 32'h00000000;
               fnum <= 8'h00;
               fflag <= 1'b0;
            end else if (!freq_en) begin
               gcnt <= 32'h00000000;
               ecnt <= 24'h000000;
               fsum <= 32'h00000000;
               fnum <= 8'h00;
               fflag <= 1'b0;
            end else if (gate_end) begin
               gcnt <= 32'h00000000;
               ecnt <= 24'h000000;
               // flag moves only after 2^avg gates
               if (avg_end) begin
                  fsum <= 32'h00000000;
                  fnum <= 8'h00;
                  // clear below valid, set above invalid
                  fflag <= hyst(fflag, fsum_now >> avg, clamp_thr(fthr[15:0], avg),
                     clamp_thr(fthr[31:16], avg));
               end else begin
                  fsum <= fsum_now;
                  fnum <= fnum + 8'h01;
               end
            end else begin
               gcnt <= gcnt + 32'h00000001;
               ecnt <= ecnt_now;
            end
         end

         // shared interval counter for window and phase valid checks
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               wcnt <= 32'h00000000;
               late_f <= 1'b0;
               early_f <= 1'b0;
               phv_f <= 1'b0;
            end else begin
               if (edge_seen)
                  wcnt <= 32'h00000000;
               else if (wcnt != 32'hFFFFFFFF)
                  wcnt <= wcnt + 32'h00000001;
               // pulse in time clears, deadline passed sets
               if (!late_en)
                  late_f <= 1'b0;
               else if (edge_seen)
                  late_f <= 1'b0;
               else if (wcnt >= late_lim)
                  late_f <= 1'b1;
               // early pulse sets at once, later pulse clears
               if (!early_en)
                  early_f <= 1'b0;
               else if (edge_seen)
                  early_f <= (wcnt < early_lim);
               if (!phv_en)
                  phv_f <= 1'b0;
               else if (edge_seen)
                  // too short an interval is a phase valid violation
                  phv_f <= (wcnt < phv_lo) | (wcnt > phv_hi);
               else if (wcnt > phv_hi)
                  phv_f <= 1'b1;
            end
         end

         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               vcnt <= 32'h00000000;
               qual <= 1'b0;
            end else if (any_flag) begin
               // drop at once and restart timer
               vcnt <= 32'h00000000;
               qual <= 1'b0;
            end else if (!ctrl[`RML_CTRL_VTIMER_EN]) begin
               qual <= 1'b1;
            end else if (vcnt >= vtime) begin
               qual <= 1'b1;
            end else begin
               vcnt <= vcnt + 32'h00000001;
            end
         end

         assign ref_freq_fault_flag[gi] = fflag;
         // late and early ORed into one window flag
         assign ref_window_fault_flag[gi] = late_f | early_f;
         assign ref_phv_fault_flag[gi] = phv_f;
         assign qual_int[gi] = qual;
      end
   endgenerate

   // ==========================================
   // pll lock detectors
   wire [2:0] lavg = lcfg[2:0];
   wire res_mode = lcfg[`RML_LCFG_RES_MODE];
   wire dpll_en = lcfg[`RML_LCFG_DPLL_EN];
   reg [31:0] dsum;
   reg [31:0] rsum;
   reg [7:0] lnum;
   wire [31:0] dsum_now = dsum + {16'h0000, dpll_freq_err};
   wire [31:0] rsum_now = rsum + {16'h0000, resonator_freq_err};
   wire lavg_end = (lnum == ((8'h01 << lavg) - 8'h01));

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dsum <= 32'h00000000;
         rsum <= 32'h00000000;
         lnum <= 8'h00;
         freq_lock_loss_flag <= 1'b1;
         phase_lock_loss_flag <= 1'b1;
         apll_lock_loss_flag <= 1'b1;
      end else begin
         // resonator mode leaves the dpll with phase lock only
         if (res_mode)
            freq_lock_loss_flag <= 1'b0;
         if (!res_mode)
            apll_lock_loss_flag <= 1'b0;
         else if (!dpll_en)
            apll_lock_loss_flag <= 1'b1;
         if (!dpll_en) begin
            phase_lock_loss_flag <= 1'b1;
            if (!res_mode)
               freq_lock_loss_flag <= 1'b1;
         end
         if (lock_err_valid && dpll_en) begin
            phase_lock_loss_flag <= hyst(phase_lock_loss_flag, {16'h0000, dpll_phase_err},
               plock[15:0], plock[31:16]);
            if (lavg_end) begin
               dsum <= 32'h00000000;
               rsum <= 32'h00000000;
               lnum <= 8'h00;
               if (!res_mode)
                  freq_lock_loss_flag <= hyst(freq_lock_loss_flag, dsum_now >> lavg,
                     clamp_thr(flock[15:0], lavg), clamp_thr(flock[31:16], lavg));
               else
                  apll_lock_loss_flag <= hyst(apll_lock_loss_flag, rsum_now >> lavg,
                     clamp_thr(rlock[15:0], lavg), clamp_thr(rlock[31:16], lavg));
            end else begin
               dsum <= dsum_now;
               rsum <= rsum_now;
               lnum <= lnum + 8'h01;
            end
         end
      end
   end

   // ==========================================
   // registered outputs
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ref_qualified <= 2'b00;
         lock_loss_status <= 1'b1;
         status_pin <= 2'b00;
      end else begin
         ref_qualified <= qual_int;
         lock_loss_status <= freq_lock_loss_flag | phase_lock_loss_flag | apll_lock_loss_flag;
         // any input's flag routable to a pin
         status_pin[0] <= pick(route[3:0], ref_freq_fault_flag, ref_window_fault_flag,
            ref_phv_fault_flag, qual_int, {lock_loss_status, apll_lock_loss_flag,
            phase_lock_loss_flag, freq_lock_loss_flag});
         status_pin[1] <= pick(route[`RML_ROUTE_PIN1_LSB+3:`RML_ROUTE_PIN1_LSB], ref_freq_fault_flag,
            ref_window_fault_flag, ref_phv_fault_flag, qual_int, {lock_loss_status,
            apll_lock_loss_flag, phase_lock_loss_flag, freq_lock_loss_flag});
      end
   end

endmodule

// ==== include/rml_defines.vh ====
// register map, field positions, reset values and constants of the reference monitor
`ifndef RML_DEFINES_VH
`define RML_DEFINES_VH
// ==========================================
// bus geometry (word index = wb_adr_i[6:2])
`define RML_ADR_W 8
`define RML_IDX_W 5
`define RML_IN_STRIDE 8
`define RML_CFG_WORDS 16
// ==========================================
// per-input block, word index inside the block
`define RML_REG_CTRL 3'h0
`define RML_REG_FTHR 3'h1
`define RML_REG_FGATE 3'h2
`define RML_REG_FCFG 3'h3
`define RML_REG_WNOM 3'h4
`define RML_REG_WWIN 3'h5
`define RML_REG_PJIT 3'h6
`define RML_REG_VTIME 3'h7
// ==========================================
// global registers, word index
`define RML_REG_ROUTE 5'h10
`define RML_REG_STATUS 5'h11
`define RML_REG_FLOCK 5'h12
`define RML_REG_PLOCK 5'h13
`define RML_REG_RLOCK 5'h14
`define RML_REG_LCFG 5'h15
`define RML_REG_LSTAT 5'h16
// ==========================================
// field positions
`define RML_CTRL_FREQ_EN 0
`define RML_CTRL_LATE_EN 1
`define RML_CTRL_EARLY_EN 2
`define RML_CTRL_PHV_EN 3
`define RML_CTRL_VTIMER_EN 4
`define RML_LCFG_RES_MODE 4
`define RML_LCFG_DPLL_EN 5
`define RML_ROUTE_PIN1_LSB 8
// ==========================================
// status pin source codes
`define RML_SRC_FREQ 3'h0
`define RML_SRC_WIN 3'h1
`define RML_SRC_PHV 3'h2
`define RML_SRC_QUAL 3'h3
`define RML_SRC_FREQ_LOCK_LOSS_FLAG 3'h4
`define RML_SRC_PHASE_LOCK_LOSS_FLAG 3'h5
`define RML_SRC_RLOFL 3'h6
`define RML_SRC_LOL 3'h7
// ==========================================
// reset values and constants
`define RML_RST_WORD 32'h00000000
`define RML_PPM_FULL 24'hF4240
`define RML_THR_MAX 16'hFFFF
`endif

// ==== verification/rml_ref_monitor_monitor.sv ====
// checker: bus handshake and lock flag relations of the reference monitor
`timescale 1ns/1ps
module rml_ref_monitor_monitor (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // lock side
   input wire lock_err_valid,
   input wire freq_lock_loss_flag,
   input wire phase_lock_loss_flag,
   input wire apll_lock_loss_flag,
   input wire lock_loss_status
);
   reg [2:0] up_cnt;
   // ==========================================
   // settle counter after reset
   // forced lock flags need a few edges to leave their reset value
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         up_cnt <= 3'h0;
      end else if (up_cnt != 3'h7) begin
         up_cnt <= up_cnt + 3'h1;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   // ==========================================
   // properties
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause;
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h00000000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_lol_or;
      lock_loss_status == $past(freq_lock_loss_flag || phase_lock_loss_flag || apll_lock_loss_flag);
   endproperty
   a_lol_or: assert property (p_lol_or) else $error("lock loss summary wrong");
   property p_lock_excl;
      up_cnt == 3'h7 |-> !(freq_lock_loss_flag && apll_lock_loss_flag);
   endproperty
   a_lock_excl: assert property (p_lock_excl) else $error("both frequency lock flags set");
   property p_phase_lock_loss_flag_fall;
      $fell(phase_lock_loss_flag) |-> $past(lock_err_valid) || $past(lock_err_valid, 2);
   endproperty
   a_phase_lock_loss_flag_fall: assert property (p_phase_lock_loss_flag_fall) else $error("phase lock cleared without sample");
   property p_phase_lock_loss_flag_rise;
      $rose(phase_lock_loss_flag) |-> $past(lock_err_valid) || $past(lock_err_valid, 2)
         || $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2);
   endproperty
   a_phase_lock_loss_flag_rise: assert property (p_phase_lock_loss_flag_rise) else $error("phase lock lost without cause");
endmodule
bind rml_ref_monitor rml_ref_monitor_monitor rml_ref_monitor_monitor_i (.clock(clock), .reset_n(reset_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .lock_err_valid(lock_err_valid), .freq_lock_loss_flag(freq_lock_loss_flag),
   .phase_lock_loss_flag(phase_lock_loss_flag), .apll_lock_loss_flag(apll_lock_loss_flag),
   .lock_loss_status(lock_loss_status));

// ==== verification/rml_ref_source.sv ====
// model of the two external reference clock sources
`timescale 1ns/1ps
module rml_ref_source (
   // half period per input in ns, zero stops the line low
   input wire [15:0] half0,
   input wire [15:0] half1,
   // reference clocks
   output reg [1:0] ref_clk
);
   initial ref_clk = 2'h0;
   // ==========================================
   // free-running sources, stopped line rests low
   // rates follow half0 and half1, half periods from 1 to 65535 ns
   always begin
      if (half0 == 16'h0000) begin
         ref_clk[0] = 1'b0;
         #7;
      end else begin
         #(half0) ref_clk[0] = ~ref_clk[0];
      end
   end
   always begin
      if (half1 == 16'h0000) begin
         ref_clk[1] = 1'b0;
         #11;
      end else begin
         #(half1) ref_clk[1] = ~ref_clk[1];
      end
   end
endmodule

// ==== verification/rml_ref_monitor_bench.sv ====
// self-checking bench of the reference monitor with random bus data and lock samples
`timescale 1ns/1ps
module rml_ref_monitor_bench;
   reg clock;
   reg reset_n;
   reg wb_cyc_i, wb_stb_i, wb_we_i, ref_selected, lock_err_valid, ef, ep, ea;
   reg [7:0] wb_adr_i;
   reg [31:0] wb_dat_i, seed, rd;
   reg [3:0] wb_sel_i;
   reg [15:0] dpll_freq_err, dpll_phase_err, resonator_freq_err, half0, half1, rv;
   reg [55:0] tbl;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, freq_lock_loss_flag, phase_lock_loss_flag, apll_lock_loss_flag, lock_loss_status;
   wire [1:0] ref_clk_in, ref_qualified, status_pin;
   integer error_cnt, check_count, i, took;
   rml_ref_monitor rml_ref_monitor_i (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_clk_in(ref_clk_in), .ref_selected(ref_selected),
      .ref_qualified(ref_qualified), .lock_err_valid(lock_err_valid), .dpll_freq_err(dpll_freq_err),
      .dpll_phase_err(dpll_phase_err), .resonator_freq_err(resonator_freq_err),
      .freq_lock_loss_flag(freq_lock_loss_flag), .phase_lock_loss_flag(phase_lock_loss_flag),
      .apll_lock_loss_flag(apll_lock_loss_flag), .lock_loss_status(lock_loss_status), .status_pin(status_pin));
   rml_ref_source rml_ref_source_i (.half0(half0), .half1(half1), .ref_clk(ref_clk_in));
   // ==========================================
   // helpers
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // thresholds: lock 0x64, unlock 0x12C, in between holds
   function hyst(input cur, input [15:0] err);
      hyst = (err < 16'h0064) ? 1'b0 : ((err > 16'h012C) ? 1'b1 : cur);
   endfunction
   task conclude;
      begin
         if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   task check(input string what, input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task wb(input we, input [7:0] adr, input [31:0] dat, input [3:0] sel);
      integer n;
      begin
         @(posedge clock);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= we;
         wb_adr_i <= adr;
         wb_dat_i <= dat;
         wb_sel_i <= sel;
         n = 0;
         @(posedge clock);
         while (wb_ack_o !== 1'b1) begin
            n = n + 1;
            if (n > 20) begin
               check("bus ack", 0, 1);
               conclude;
            end
            @(posedge clock);
         end
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
      end
   endtask
   task wait_q(input integer k, input v, input integer lim);
      begin
         took = 0;
         while (ref_qualified[k] !== v) begin
            @(posedge clock);
            took = took + 1;
            if (took > lim) begin
               check("qualified wait", ref_qualified[k], v);
               conclude;
            end
         end
      end
   endtask
   task sample(input [15:0] f, input [15:0] p, input [15:0] r);
      begin
         @(posedge clock);
         dpll_freq_err <= f;
         dpll_phase_err <= p;
         resonator_freq_err <= r;
         lock_err_valid <= 1'b1;
         @(posedge clock);
         lock_err_valid <= 1'b0;
         repeat (4) @(posedge clock);
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // ==========================================
   // main sequence
   initial begin
      {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, ref_selected, lock_err_valid} = 6'h00;
      {wb_adr_i, wb_dat_i, wb_sel_i} = 44'h0;
      {dpll_freq_err, dpll_phase_err, resonator_freq_err, half0, half1} = 80'h0;
      error_cnt = 0;
      check_count = 0;
      seed = 32'h78A037B5;
      tbl = 56'h504C4834241404;
      repeat (16) @(posedge clock);
      check("reset lock", {freq_lock_loss_flag, phase_lock_loss_flag, apll_lock_loss_flag, lock_loss_status},
         4'hF);
      check("reset qual", ref_qualified, 2'h0);
      reset_n <= 1'b1;
      wb(1'b1, 8'h58, 32'hFFFFFFFF, 4'hF);
      wb(1'b0, 8'h58, 32'h0, 4'hF);
      check("lstat", rd, 32'hB);
      check("idle qual", ref_qualified, 2'h3);
      for (i = 0; i < 7; i = i + 1) begin
         seed = lfsr(seed);
         wb(1'b1, tbl[8*i +: 8], seed, 4'hF);
         wb(1'b0, tbl[8*i +: 8], 32'h0, 4'hF);
         check("readback", rd, seed);
      end
      wb(1'b1, 8'h04, 32'hA5A5A5A5, 4'hF);
      wb(1'b1, 8'h04, 32'h3C3C3C3C, 4'h2);
      wb(1'b0, 8'h04, 32'h0, 4'hF);
      check("lane write", rd, 32'hA5A53CA5);
      wb(1'b1, 8'h5C, 32'hFFFFFFFF, 4'hF);
      wb(1'b0, 8'h5C, 32'h0, 4'hF);
      check("unmapped", rd, 32'h0);
      // window detector on input 0: period 32, late and early margin 8, timer 150
      wb(1'b1, 8'h10, 32'h20, 4'hF);
      wb(1'b1, 8'h14, 32'h00080008, 4'hF);
      wb(1'b1, 8'h1C, 32'h96, 4'hF);
      wb(1'b1, 8'h40, 32'hB01, 4'hF);
      wb(1'b1, 8'h00, 32'h16, 4'hF);
      wait_q(0, 1'b0, 100);
      half0 <= 16'd80;
      wait_q(0, 1'b1, 600);
      check("qual delay", took >= 150, 1);
      wb(1'b0, 8'h44, 32'h0, 4'hF);
      check("status ok", rd, 32'h8);
      check("pins ok", status_pin, 2'h2);
      half0 <= 16'd0;
      wait_q(0, 1'b0, 80);
      repeat (2) @(posedge clock);
      check("pins late", status_pin, 2'h3);
      wb(1'b0, 8'h44, 32'h0, 4'hF);
      check("status late", rd, 32'h102);
      ref_selected <= 1'b1;
      wb(1'b0, 8'h44, 32'h0, 4'hF);
      check("status sel", rd, 32'h118);
      ref_selected <= 1'b0;
      half0 <= 16'd80;
      wait_q(0, 1'b1, 600);
      check("requal delay", took >= 150, 1);
      half0 <= 16'd40;
      wait_q(0, 1'b0, 60);
      wb(1'b1, 8'h00, 32'h14, 4'hF);
      wait_q(0, 1'b1, 600);
      // frequency monitor alone: 960-clock gate, 30 edges nominal, one edge is 32768 ppm
      wb(1'b1, 8'h08, 32'h3BF, 4'hF);
      wb(1'b1, 8'h0C, 32'hF, 4'hF);
      wb(1'b1, 8'h04, 32'hF000C000, 4'hF);
      wb(1'b1, 8'h00, 32'h1, 4'hF);
      wait_q(0, 1'b0, 1100);
      half0 <= 16'd80;
      wait_q(0, 1'b1, 2100);
      half0 <= 16'd0;
      // phase valid alone on input 1, jitter margin 4
      wb(1'b1, 8'h30, 32'h20, 4'hF);
      wb(1'b1, 8'h38, 32'h4, 4'hF);
      wb(1'b1, 8'h20, 32'h08, 4'hF);
      wait_q(1, 1'b0, 100);
      half1 <= 16'd80;
      wait_q(1, 1'b1, 200);
      half1 <= 16'd0;
      wait_q(1, 1'b0, 60);
      // lock detectors, single-sample averaging
      wb(1'b1, 8'h48, 32'h012C0064, 4'hF);
      wb(1'b1, 8'h4C, 32'h012C0064, 4'hF);
      wb(1'b1, 8'h50, 32'h012C0064, 4'hF);
      wb(1'b1, 8'h54, 32'h20, 4'hF);
      {ef, ep, ea} = 3'b110;
      for (i = 0; i < 40; i = i + 1) begin
         seed = lfsr(seed);
         if (i == 20) begin
            wb(1'b1, 8'h54, 32'h30, 4'hF);
         end
         rv = (i == 20) ? 16'h0190 : {7'h0, seed[26:18]};
         sample({7'h0, seed[8:0]}, {7'h0, seed[17:9]}, rv);
         ef = (i < 20) ? hyst(ef, {7'h0, seed[8:0]}) : 1'b0;
         ep = hyst(ep, {7'h0, seed[17:9]});
         ea = (i < 20) ? 1'b0 : hyst(ea, rv);
         check("lock flags", {freq_lock_loss_flag, phase_lock_loss_flag, apll_lock_loss_flag, lock_loss_status},
            {ef, ep, ea, ef | ep | ea});
      end
      wb(1'b1, 8'h40, 32'h406, 4'hF);
      wb(1'b1, 8'h54, 32'h10, 4'hF);
      repeat (3) @(posedge clock);
      check("no dpll", {freq_lock_loss_flag, phase_lock_loss_flag, apll_lock_loss_flag}, 3'b011);
      check("pins lock", status_pin, 2'h1);
      conclude;
   end
endmodule
